/* File: dcs_cfg.svh */
// register offsets, reset words and write masks for the channel scheduler config block
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ==========================================================
// register offsets (dword access)
`define DCS_OFS_WRITE_QUEUE_THRESHOLDS 8'hb4
`define DCS_OFS_SCHEDULER_CONTROL      8'hb8
`define DCS_OFS_MAINTENANCE_INTERVAL   8'hbc
`define DCS_OFS_TX_CROSSING_RATIOS     8'hc0

// ==========================================================
// reset words
`define DCS_RST_WRITE_QUEUE_THRESHOLDS 32'h0dff_fed6
`define DCS_RST_SCHEDULER_CONTROL      32'h0000_11c0
`define DCS_RST_MAINTENANCE_INTERVAL   32'h0000_0000
`define DCS_RST_TX_CROSSING_RATIOS     32'h0002_0104

// ==========================================================
// writable bits; reserved bits read as zero
`define DCS_MSK_WRITE_QUEUE_THRESHOLDS 32'h3fff_ffff
`define DCS_MSK_SCHEDULER_CONTROL      32'h0000_1fef
`define DCS_MSK_MAINTENANCE_INTERVAL   32'h0000_1fff
`define DCS_MSK_TX_CROSSING_RATIOS     32'h00ff_ffff

// ==========================================================
// field values with special meaning
`define DCS_UNDERFILL_OFF              5'h1f
`define DCS_PRIO_LOW_BITS              5'h1f

`endif

/* File: dcs_channel_config.sv */
// channel scheduler configuration registers and the decisions they steer
// Behaviour
// - enter write-major mode when queued writes exceed the entry level
// - leave write-major mode when queued writes drop below the exit level
// - with a read pending, enter when writes exceed the realtime entry level
// - with a read pending, exit when writes drop below the realtime exit level
// - underfill priority raised above its limit; limit 31 disables the boost
// - medium-low reads may not early-CAS writes above the write-side limit
// - medium-low reads may early-CAS writes above the read-side limit
// - when enabled, assert chip select on clock enable transitions
// - when enabled, float address and command lines while idle
// - when set, hold no read buffer credits for realtime traffic
// - command timing is 2N when set, 1N when clear
// - priority timeout field gives upper three bits of the 8-bit counter limit, low five bits all ones
// - maintenance interval value loads the maintenance counter pacing calibration
// - transmit crossing core clock multiple, 8 bits, reset 4
// - transmit crossing dram clock multiple, 8 bits, reset 1
// - transmit crossing offset, 8 bits, reset 2, positions command launch
`timescale 1ns/100ps
`include "dcs_cfg.svh"

module dcs_channel_config #(
    parameter int COUNT_W = 6
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic [7:0]         reg_addr,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [31:0]        reg_wdata,
    output logic [31:0]             reg_rdata,
    output logic                    reg_rvalid,
    input  wire logic [COUNT_W-1:0] wq_count,
    input  wire logic               read_pending,
    input  wire logic               cke_change,
    input  wire logic               cmd_issue,
    input  wire logic               prio_wait,
    output logic                    write_major,
    output logic                    underfill_boost,
    output logic                    early_cas_allowed,
    output logic                    select_assert,
    output logic                    cmd_float,
    output logic                    no_realtime_buffer_credit_hold,
    output logic                    two_cycle_command_timing,
    output logic                    prio_timeout,
    output logic                    maintenance_tick,
    output logic                    tx_launch,
    output dcs_pkg::dcs_tx_t        tx_cfg
);

    // ==========================================================
    // helpers: compare the queue count with a 5-bit level
    // a COUNT_W below 5 would cut the levels, so keep the count at least 5 bits wide
    function automatic logic above(input logic [COUNT_W-1:0] cnt, input logic [4:0] lvl);
        above = cnt > COUNT_W'(lvl);
    endfunction : above

    function automatic logic below(input logic [COUNT_W-1:0] cnt, input logic [4:0] lvl);
        below = cnt < COUNT_W'(lvl);
    endfunction : below

    // ==========================================================
    // register storage
    dcs_pkg::dcs_wq_thr_t wq_thr;
    dcs_pkg::dcs_sched_t  sched;
    dcs_pkg::dcs_maint_t  maint;
    dcs_pkg::dcs_tx_t     tx;

    // address decode
    wire logic hit_wq    = reg_addr == `DCS_OFS_WRITE_QUEUE_THRESHOLDS;
    wire logic hit_sched = reg_addr == `DCS_OFS_SCHEDULER_CONTROL;
    wire logic hit_maint = reg_addr == `DCS_OFS_MAINTENANCE_INTERVAL;
    wire logic hit_tx    = reg_addr == `DCS_OFS_TX_CROSSING_RATIOS;

    // read mux; unmapped offsets read as zero
    wire logic [31:0] rd_mux =
        hit_wq    ? 32'(wq_thr) :
        hit_sched ? 32'(sched)  :
        hit_maint ? 32'(maint)  :
        hit_tx    ? 32'(tx)     : 32'h0000_0000;

    // write enables; a strobe to an unmapped offset is simply ignored
    wire logic wr_wq    = reg_wr && hit_wq;
    wire logic wr_sched = reg_wr && hit_sched;
    wire logic wr_maint = reg_wr && hit_maint;
    wire logic wr_tx    = reg_wr && hit_tx;

    // threshold word; reserved top bits are masked so they read zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wq_thr <= `DCS_RST_WRITE_QUEUE_THRESHOLDS;
        else if (wr_wq)
            wq_thr <= reg_wdata & `DCS_MSK_WRITE_QUEUE_THRESHOLDS;
    end

    // scheduler word; the reserved bit between credit hold and 2N stays zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sched <= `DCS_RST_SCHEDULER_CONTROL;
        else if (wr_sched)
            sched <= reg_wdata & `DCS_MSK_SCHEDULER_CONTROL;
    end

    // maintenance interval; only the low 13 bits hold state
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            maint <= `DCS_RST_MAINTENANCE_INTERVAL;
        else if (wr_maint)
            maint <= reg_wdata & `DCS_MSK_MAINTENANCE_INTERVAL;
    end

    // crossing ratios and offset; the top byte is reserved
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            tx <= `DCS_RST_TX_CROSSING_RATIOS;
        else if (wr_tx)
            tx <= reg_wdata & `DCS_MSK_TX_CROSSING_RATIOS;
    end

    // read data returns one cycle after the strobe
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // ==========================================================
    // write-major mode
    dcs_pkg::dcs_mode_t mode;
    dcs_pkg::dcs_mode_t next_mode;

    wire logic enter_hit = read_pending
        ? above(wq_count, wq_thr.realtime_write_mode_entry_level)
        : above(wq_count, wq_thr.write_mode_entry_level);   // plain entry
    wire logic exit_hit = read_pending
        ? below(wq_count, wq_thr.realtime_write_mode_exit_level)
        : below(wq_count, wq_thr.write_mode_exit_level);    // plain exit

    always_comb
    begin
        next_mode = mode;
        case (mode)
            dcs_pkg::DCS_NORMAL:
                if (enter_hit)
                    next_mode = dcs_pkg::DCS_WRITE_MAJOR;
            dcs_pkg::DCS_WRITE_MAJOR:
                if (exit_hit)
                    next_mode = dcs_pkg::DCS_NORMAL;
            default:
                next_mode = dcs_pkg::DCS_NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            mode <= dcs_pkg::DCS_NORMAL;
        else
            mode <= next_mode;
    end

    assign write_major = mode == dcs_pkg::DCS_WRITE_MAJOR;

    // ==========================================================
    // scheduler priority decisions
    // limit of 31 switches the boost off
    wire logic next_boost = (wq_thr.underfill_priority_limit != `DCS_UNDERFILL_OFF)
                            && above(wq_count, wq_thr.underfill_priority_limit);
    // read side permits, write side forbids; forbid wins
    wire logic next_early_cas = above(wq_count, sched.read_side_early_cas_limit)
                                && !above(wq_count, wq_thr.write_side_early_cas_limit);

    // registered so the scheduler sees glitch-free decisions
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            underfill_boost   <= 1'b0;
            early_cas_allowed <= 1'b0;
        end
        else
        begin
            underfill_boost   <= next_boost;
            early_cas_allowed <= next_early_cas;
        end
    end

    // ==========================================================
    // command pin behaviour
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            select_assert <= 1'b0;
            cmd_float     <= 1'b0;
        end
        else
        begin
            // chip select on power-down or self-refresh transitions
            select_assert <= cke_change && sched.select_on_clock_enable_change;
            // float only when idle; not advised for registered modules
            cmd_float     <= sched.command_float && !cmd_issue;
        end
    end

    assign no_realtime_buffer_credit_hold = sched.no_realtime_buffer_credit_hold;
    // 2N when set, 1N when clear
    assign two_cycle_command_timing = sched.two_cycle_command_timing;

    // ==========================================================
    // priority timeout counter
    logic [7:0] prio_cnt;
    // field forms the top three bits of the 8-bit limit
    wire logic [7:0] prio_limit = {sched.priority_timeout_upper_bits, `DCS_PRIO_LOW_BITS};
    wire logic       prio_hit   = prio_wait && (prio_cnt == prio_limit);

    // counts only while a request waits; restarts after each timeout
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prio_cnt     <= 8'h00;
            prio_timeout <= 1'b0;
        end
        else
        begin
            prio_timeout <= prio_hit;
            if (!prio_wait || prio_hit)
                prio_cnt <= 8'h00;
            else
                prio_cnt <= prio_cnt + 8'h01;
        end
    end

    // ==========================================================
    // maintenance interval counter
    logic [12:0] maint_cnt;
    wire  logic  maint_on  = maint.maintenance_interval_value != 13'h0000;
    wire  logic  maint_exp = maint_on && (maint_cnt == 13'h0000);

    // loads the programmed interval; reload on expiry, zero idles
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            maint_cnt        <= 13'h0000;
            maintenance_tick <= 1'b0;
        end
        else
        begin
            maintenance_tick <= maint_exp;
            if (!maint_on || maint_exp)
                maint_cnt <= maint.maintenance_interval_value;
            else
                maint_cnt <= maint_cnt - 13'h0001;
        end
    end

    // ==========================================================
    // transmit crossing launch phase
    logic [7:0] tx_phase;
    // phase wraps at the core clock multiple; zero treated as one
    wire logic [7:0] tx_last = (tx.core_clock_multiple == 8'h00)
                               ? 8'h00 : tx.core_clock_multiple - 8'h01;
    wire logic       tx_wrap = tx_phase >= tx_last;

    // launch slot sits at the offset; software keeps it below the multiple
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_phase  <= 8'h00;
            tx_launch <= 1'b0;
        end
        else
        begin
            tx_launch <= tx_phase == tx.offset;
            tx_phase  <= tx_wrap ? 8'h00 : tx_phase + 8'h01;
        end
    end

    // dram multiple passed to the crossing with the other settings
    assign tx_cfg = tx;

endmodule : dcs_channel_config

/* File: dcs_channel_config_properties.sv */
// port-level assertions for the channel scheduler config block
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_checker #(
    parameter int COUNT_W = 6
) (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic [7:0]         reg_addr,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_wdata,
    input wire logic [31:0]        reg_rdata,
    input wire logic               reg_rvalid,
    input wire logic [COUNT_W-1:0] wq_count,
    input wire logic               read_pending,
    input wire logic               cke_change,
    input wire logic               cmd_issue,
    input wire logic               prio_wait,
    input wire logic               write_major,
    input wire logic               underfill_boost,
    input wire logic               select_assert,
    input wire logic               cmd_float,
    input wire logic               prio_timeout,
    input wire logic               maintenance_tick
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [31:0] thr;
    logic [6:0]  wait_cnt;
    // ====
    // shadow of the threshold word; the levels are not visible at the ports
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            thr <= `DCS_RST_WRITE_QUEUE_THRESHOLDS;
        else if (reg_wr && reg_addr == `DCS_OFS_WRITE_QUEUE_THRESHOLDS)
            thr <= reg_wdata;
    end
    // cycles in a row with a request waiting, saturating
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wait_cnt <= '0;
        else if (!prio_wait)
            wait_cnt <= '0;
        else if (wait_cnt != 7'h7f)
            wait_cnt <= wait_cnt + 7'h01;
    end
    // a pending read switches to the realtime levels
    wire [4:0] ent = read_pending ? thr[14:10] : thr[9:5];
    wire [4:0] ext = read_pending ? thr[19:15] : thr[4:0];
    wire bst = wq_count > COUNT_W'(thr[24:20]) && thr[24:20] != 5'h1f;
    wire mapped = reg_addr inside {8'hb4, 8'hb8, 8'hbc, 8'hc0};
    // ====
    rvalid_pulse_a: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");
    mode_entry_a: assert property (!write_major && wq_count > COUNT_W'(ent) |=> write_major)
        else $error("write-major mode not entered");
    mode_exit_a: assert property (write_major && wq_count < COUNT_W'(ext) |=> !write_major)
        else $error("write-major mode not left");
    underfill_boost_a: assert property (1'b1 |=> underfill_boost == $past(bst))
        else $error("underfill boost wrong");
    select_cause_a: assert property (select_assert |-> $past(cke_change))
        else $error("chip select without clock enable change");
    float_idle_a: assert property (cmd_float |-> !$past(cmd_issue))
        else $error("command lines floated while issuing");
    tick_single_a: assert property (maintenance_tick |=> !maintenance_tick)
        else $error("maintenance tick longer than one cycle");
    prio_wait_a: assert property (prio_timeout |-> wait_cnt >= 7'd32 ##1 !prio_timeout [*8])
        else $error("priority timeout too early");
    cover property ($rose(write_major));
    cover property (prio_timeout);
    cover property (maintenance_tick);
endmodule : dcs_checker
bind dcs_channel_config dcs_checker #(.COUNT_W(COUNT_W)) dcs_checker_inst (.*);

/* File: dcs_pkg.sv */
// types shared by the channel scheduler config block
package dcs_pkg;

    // ==========================================================
    // register layouts
    typedef struct packed {
        logic [1:0] rsvd;
        logic [4:0] write_side_early_cas_limit;
        logic [4:0] underfill_priority_limit;
        logic [4:0] realtime_write_mode_exit_level;
        logic [4:0] realtime_write_mode_entry_level;
        logic [4:0] write_mode_entry_level;
        logic [4:0] write_mode_exit_level;
    } dcs_wq_thr_t;

    typedef struct packed {
        logic [18:0] rsvd_hi;
        logic        select_on_clock_enable_change;
        logic        command_float;
        logic [4:0]  read_side_early_cas_limit;
        logic        no_realtime_buffer_credit_hold;
        logic        rsvd_lo;
        logic        two_cycle_command_timing;
        logic [2:0]  priority_timeout_upper_bits;
    } dcs_sched_t;

    typedef struct packed {
        logic [18:0] rsvd;
        logic [12:0] maintenance_interval_value;
    } dcs_maint_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic [7:0] offset;
        logic [7:0] dram_clock_multiple;
        logic [7:0] core_clock_multiple;
    } dcs_tx_t;

    // ==========================================================
    // write-major mode states
    typedef enum logic {
        DCS_NORMAL,
        DCS_WRITE_MAJOR
    } dcs_mode_t;

endpackage : dcs_pkg

/* File: dcs_queue_model.sv */
// write queue stand-in feeding the live queued-write count
`timescale 1ns/100ps
module dcs_queue_model #(
    parameter int COUNT_W = 6
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic [COUNT_W-1:0] target,
    output logic      [COUNT_W-1:0] wq_count
);
    // ====
    // one write taken or retired per cycle, never a jump
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wq_count <= '0;
        else if (wq_count < target)
            wq_count <= wq_count + COUNT_W'(1);
        else if (wq_count > target)
            wq_count <= wq_count - COUNT_W'(1);
    end
endmodule : dcs_queue_model

/* File: dram_channel_scheduler_config_tb_top.sv */
// self-checking bench for the channel scheduler config block
`timescale 1ns/100ps
module dram_channel_scheduler_config_tb_top;
    logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic [5:0] target = 6'h00, wq_count;
    logic read_pending = 1'b0, cke_change = 1'b0, cmd_issue = 1'b0, prio_wait = 1'b0;
    logic reg_rvalid, write_major, underfill_boost, early_cas, select_assert, cmd_float;
    logic no_rt, two_cyc, prio_timeout, maintenance_tick, tx_launch;
    dcs_pkg::dcs_tx_t tx_cfg;
    int n_fail = 0, n_compared = 0, n;
    dcs_channel_config #(.COUNT_W(6)) dcs_channel_config_inst (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .wq_count(wq_count), .read_pending(read_pending),
        .cke_change(cke_change), .cmd_issue(cmd_issue), .prio_wait(prio_wait),
        .write_major(write_major), .underfill_boost(underfill_boost),
        .early_cas_allowed(early_cas), .select_assert(select_assert), .cmd_float(cmd_float),
        .no_realtime_buffer_credit_hold(no_rt), .two_cycle_command_timing(two_cyc),
        .prio_timeout(prio_timeout), .maintenance_tick(maintenance_tick),
        .tx_launch(tx_launch), .tx_cfg(tx_cfg));
    dcs_queue_model #(.COUNT_W(6)) dcs_queue_model_inst (
        .ref_clk(ref_clk), .resetn(resetn), .target(target), .wq_count(wq_count));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ====
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // read data is registered: take it just after the edge that saw the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // move the queue count, then let the decision register catch up
    task automatic settle(input logic [5:0] x);
        int i;
        @(posedge ref_clk) target <= x;
        cyc(1);
        for (i = 0; i < 70 && wq_count !== x; i++)
            cyc(1);
        if (i >= 70)
        begin
            n_fail++;
            $display("Error wq_count expected %0d seen %0d", x, wq_count);
            test_done();
        end
        cyc(1);
    endtask : settle
    function automatic logic pick(input int s);
        return s == 0 ? maintenance_tick : (s == 1 ? tx_launch : prio_timeout);
    endfunction : pick
    // cycles between two pulses of one output
    task automatic gap(input int s, output int g);
        int i;
        g = 1;
        for (i = 0; i < 300 && pick(s) !== 1'b1; i++)
            cyc(1);
        cyc(1);
        for (; g < 300 && pick(s) !== 1'b1; g++)
            cyc(1);
        if (i >= 300 || g >= 300)
        begin
            n_fail++;
            $display("Error pulse gap expected below 300 seen %0d", g);
            test_done();
        end
    endtask : gap
    // launch offset as software works it out, core clock taken as 20000 ps
    function automatic logic [7:0] tx_offset(input int u, input int d);
        int g, r, t, m, dly;
        g = u;
        r = d;
        while (r != 0)
        begin
            t = g % r;
            g = r;
            r = t;
        end
        dly = 8 * 20000 + 670;
        m = 0;
        while (((m + 1) / g) * 20000 * g <= dly * d)
            m++;
        return 8'(m % u);
    endfunction : tx_offset
    // ====
    task automatic t_regs;
        logic [7:0] ofs [4] = '{8'hb4, 8'hb8, 8'hbc, 8'hc0};
        logic [31:0] rst [4] = '{32'h0dff_fed6, 32'h0000_11c0, 32'h0000_0000, 32'h0002_0104};
        logic [31:0] msk [4] = '{32'h3fff_ffff, 32'h0000_1fef, 32'h0000_1fff, 32'h00ff_ffff};
        for (int k = 0; k < 4; k++)
        begin
            rd(ofs[k], d);
            chk("reset word", rst[k], d);
            wr(ofs[k], 32'hffff_ffff);
            rd(ofs[k], d);
            chk("write mask", msk[k], d);
            wr(ofs[k], rst[k]);
        end
        wr(8'ha0, 32'hffff_ffff);
        rd(8'ha0, d);
        chk("unmapped", 32'h0000_0000, d);
    endtask : t_regs
    task automatic t_mode;
        settle(6'd22);
        chk("write_major", 0, write_major);
        settle(6'd23);
        chk("write_major", 1, write_major);
        settle(6'd22);
        chk("write_major", 1, write_major);
        settle(6'd21);
        chk("write_major", 0, write_major);
        @(posedge ref_clk) read_pending <= 1'b1;
        settle(6'd31);
        chk("write_major", 0, write_major);
        settle(6'd32);
        chk("write_major", 1, write_major);
        settle(6'd30);
        chk("write_major", 0, write_major);
        @(posedge ref_clk) read_pending <= 1'b0;
    endtask : t_mode
    task automatic t_sched;
        wr(8'hb4, 32'h0c5f_fed6);
        settle(6'd6);
        chk("underfill_boost", 1, underfill_boost);
        settle(6'd5);
        chk("underfill_boost", 0, underfill_boost);
        wr(8'hb4, 32'h0dff_fed6);
        settle(6'd40);
        chk("underfill_boost", 0, underfill_boost);
        wr(8'hb8, 32'h0000_18a8);
        chk("no_rt", 1, no_rt);
        chk("two_cyc", 1, two_cyc);
        settle(6'd2);
        chk("early_cas", 0, early_cas);
        settle(6'd4);
        chk("early_cas", 1, early_cas);
        settle(6'd7);
        chk("early_cas", 0, early_cas);
        chk("cmd_float", 1, cmd_float);
        @(posedge ref_clk) cmd_issue <= 1'b1;
        cyc(1);
        chk("cmd_float", 0, cmd_float);
        @(posedge ref_clk) cke_change <= 1'b1;
        @(posedge ref_clk) cke_change <= 1'b0;
        cmd_issue <= 1'b0;
        #1 chk("select_assert", 1, select_assert);
        wr(8'hb8, 32'h0000_0000);
        chk("two_cyc", 0, two_cyc);
        @(posedge ref_clk) cke_change <= 1'b1;
        @(posedge ref_clk) cke_change <= 1'b0;
        #1 chk("select_assert", 0, select_assert);
        settle(6'd0);
    endtask : t_sched
    task automatic t_counts;
        wr(8'hb8, 32'h0000_11c1);
        @(posedge ref_clk) prio_wait <= 1'b1;
        gap(2, n);
        chk("prio period", 64, n);
        @(posedge ref_clk) prio_wait <= 1'b0;
        wr(8'hbc, 32'h0000_0003);
        gap(0, n);
        chk("maint period", 4, n);
        wr(8'hbc, 32'h0000_0000);
        cyc(3);
        n = 0;
        repeat (20)
        begin
            cyc(1);
            n += int'(maintenance_tick === 1'b1);
        end
        chk("maint idle ticks", 0, n);
        chk("tx_cfg", 32'h0002_0104, tx_cfg);
        gap(1, n);
        chk("launch period", 4, n);
        wr(8'hc0, {8'h00, tx_offset(3, 2), 8'h02, 8'h03});
        chk("tx_cfg", 32'h0001_0203, tx_cfg);
        gap(1, n);
        chk("launch period", 3, n);
    endtask : t_counts
    initial
    begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_mode();
        t_sched();
        t_counts();
        test_done();
    end
endmodule : dram_channel_scheduler_config_tb_top
